// file: test/test_pmt8_timer.sv
`timescale 1ns/10ps
module test_pmt8_timer;
  import pmt8_pkg::*;
  logic          i_clk;
  logic          i_sys_rst;
  pmt8_avm_req_s req;
  logic [31:0]   rdata;
  logic          wreq;
  logic          tick;
  pmt8_tbase_s   tbase;
  logic          irq;
  int            fail_count;
  int            checked;
  int            n;
  logic [7:0]    q;
  // Address, write data, expected read-back
  logic [23:0]   rows [8] = '{24'h92_5a5a, 24'h12_fb7b, 24'h11_3737, 24'h0c_ff02,
                              24'h0c_0000, 24'h8c_ff02, 24'h8c_0000, 24'h33_ff00};
  logic [15:0]   rst_rows [5] = '{16'h0c00, 16'h8c00, 16'h1100, 16'h1200, 16'h92ff};

  pmt8_timer i_pmt8_timer (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avm(req), .o_avm_readdata(rdata),
    .o_avm_waitrequest(wreq), .o_ssp_shift_tick(tick), .o_pwm_tbase(tbase), .o_irq(irq));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic wrap_up;
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    checked++;
    if (got != exp) begin
      fail_count++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  // A spare edge first, so no request is driven twice in one step
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    @(posedge i_clk);
    req <= '{address: a, read: !w, write: w, writedata: {24'h00_0000, d}};
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    q = rdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (k >= 50) chkn(k, 0);
  endtask

  task automatic rst;
    i_sys_rst <= 1'b1;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
  endtask

  task automatic gap(output int c);
    c = 0;
    do begin
      @(posedge i_clk);
      c++;
    end while (tick !== 1'b1 && c < 1000);
  endtask

  initial begin
    #240000;
    fail_count++;
    wrap_up();
  end

  initial begin
    fail_count = 0;
    checked = 0;
    req = '0;
    i_sys_rst = 1'b1;
    rst();
    foreach (rows[i]) begin
      bus(rows[i][23:16], 1'b1, rows[i][15:8]);
      bus(rows[i][23:16], 1'b0, 8'h00);
      chk8(q, rows[i][7:0]);
    end
    bus(8'h92, 1'b1, 8'h02);
    bus(8'h11, 1'b1, 8'h00);
    // Second gap is a full period; the first may be cut short by the write
    for (int p = 0; p < 4; p++) begin
      bus(8'h12, 1'b1, 8'h04 + 8'(p));
      gap(n);
      gap(n);
      chkn(n, 3 * 4 * (p == 0 ? 1 : (p == 1 ? 4 : 16)));
      chk8(tbase.count, 8'h00);
      chk8({7'h00, tbase.period_match}, 8'h01);
    end
    bus(8'h12, 1'b1, 8'h18);
    bus(8'h0c, 1'b1, 8'h00);
    bus(8'h8c, 1'b1, 8'h02);
    bus(8'h11, 1'b1, 8'h00);
    bus(8'h12, 1'b1, 8'h1c);
    n = 0;
    for (int c = 0; c < 2000 && irq !== 1'b1; c++) begin
      @(posedge i_clk);
      if (tick === 1'b1) n++;
    end
    chkn(n, 4);
    bus(8'h12, 1'b1, 8'h18);
    bus(8'h11, 1'b1, 8'h05);
    bus(8'h12, 1'b1, 8'h18);
    repeat (100) @(posedge i_clk);
    chk8({7'h00, irq}, 8'h01);
    bus(8'h11, 1'b0, 8'h00);
    chk8(q, 8'h05);
    bus(8'h8c, 1'b1, 8'h00);
    bus(8'h0c, 1'b0, 8'h00);
    chk8(q, 8'h02);
    chk8({7'h00, irq}, 8'h00);
    bus(8'h92, 1'b1, 8'h10);
    bus(8'h12, 1'b1, 8'h07);
    rst();
    foreach (rst_rows[i]) begin
      bus(rst_rows[i][15:8], 1'b0, 8'h00);
      chk8(q, rst_rows[i][7:0]);
    end
    chk8({7'h00, irq}, 8'h00);
    wrap_up();
  end
endmodule // test_pmt8_timer

// file: verilog/pmt8_pkg.sv
package pmt8_pkg;
  // Avalon word addresses (byte address = 4 * index)
  localparam logic [7:0] PMT8_ADDR_FLAGS   = 8'h0c;
  localparam logic [7:0] PMT8_ADDR_ENABLES = 8'h8c;
  localparam logic [7:0] PMT8_ADDR_COUNT   = 8'h11;
  localparam logic [7:0] PMT8_ADDR_CONTROL = 8'h12;
  localparam logic [7:0] PMT8_ADDR_PERIOD  = 8'h92;
  localparam int         PMT8_AW           = 8;

  // Field positions
  localparam int PMT8_MATCH_FLAG_BIT = 1;
  localparam int PMT8_RUN_BIT        = 2;
  localparam int PMT8_PRE_LSB        = 0;
  localparam int PMT8_POST_LSB       = 3;

  // Reset values and masks
  localparam logic [7:0] PMT8_PERIOD_RST  = 8'hff;
  localparam logic [7:0] PMT8_COUNT_RST   = 8'h00;
  localparam logic [6:0] PMT8_CONTROL_RST = 7'h00;
  localparam logic [7:0] PMT8_FLAGS_MASK  = 8'h02;

  // Prescaler terminal counts (divide minus one)
  localparam logic [3:0] PMT8_PRE_DIV1  = 4'h0;
  localparam logic [3:0] PMT8_PRE_DIV4  = 4'h3;
  localparam logic [3:0] PMT8_PRE_DIV16 = 4'hf;
  // Instruction clock is the system clock divided by four
  localparam logic [1:0] PMT8_INSTR_DIV = 2'h3;

  typedef enum logic [1:0] {
    PMT8_BUS_IDLE = 2'b00,
    PMT8_BUS_ACK  = 2'b01
  } pmt8_bus_e;

  typedef struct packed {
    logic [PMT8_AW-1:0] address;
    logic               read;
    logic               write;
    logic [31:0]        writedata;
  } pmt8_avm_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } pmt8_avm_rsp_s;

  typedef struct packed {
    logic [7:0] count;
    logic       period_match;
  } pmt8_tbase_s;
endpackage

// file: verilog/pmt8_timer.sv
`timescale 1ns/10ps
// Operation
// (R1) 8-bit counter, prescaler in, postscaler on match
// (R2) Input is instruction clock over 1/4/16
// (R3) Prescale 00 div1, 01 div4, 1x div16
// (R4) Count up, wrap to zero after period match
// (R5) Period register read/write, FFh on reset
// (R6) Count read/write, cleared by reset
// (R7) Postscaler completion sets match flag bit 1
// (R8) Postscale ratio is field value plus one
// (R9) Run bit clear stops counting
// (R10) Scalers cleared on count/control write, reset
// (R11) Control write keeps count value
// (R12) Pre-postscaler match pulse to serial port
// (R13) Count and match offered as PWM base
// (R14) Flag sticky until software clears; gated irq
module pmt8_timer
  import pmt8_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  // Avalon-MM slave
  input  wire pmt8_pkg::pmt8_avm_req_s i_avm,
  output logic [31:0]                  o_avm_readdata,
  output logic                         o_avm_waitrequest,
  // Peripheral outputs
  output logic                         o_ssp_shift_tick,
  output pmt8_pkg::pmt8_tbase_s        o_pwm_tbase,
  output logic                         o_irq
);
  import pmt8_pkg::*;

  typedef struct packed {
    pmt8_bus_e   bus;
    logic [31:0] rdata;
    logic        waitreq;
    logic [1:0]  instr_cnt;
    logic [3:0]  pre_cnt;
    logic [3:0]  post_cnt;
    logic [7:0]  count;
    logic [7:0]  period;
    logic [6:0]  control;
    logic        match_flag;
    logic        match_irq_en;
    logic        match_pulse;
    logic        irq;
  } pmt8_state_s;

  pmt8_state_s st_reg;
  pmt8_state_s st_next;

  logic       instr_tick;
  logic       pre_tick;
  logic       hit;
  logic [3:0] pre_term;
  logic       wr_acc;
  logic       rd_acc;

  always_comb begin
    st_next = st_reg;
    wr_acc  = (st_reg.bus == PMT8_BUS_IDLE) && i_avm.write;
    rd_acc  = (st_reg.bus == PMT8_BUS_IDLE) && i_avm.read && !i_avm.write;

    // Instruction clock enable: one tick per four system clocks
    instr_tick = (st_reg.instr_cnt == PMT8_INSTR_DIV);
    st_next.instr_cnt = st_reg.instr_cnt + 2'h1;

    case (st_reg.control[PMT8_PRE_LSB+:2])                        // R3
      2'b00:   pre_term = PMT8_PRE_DIV1;
      2'b01:   pre_term = PMT8_PRE_DIV4;
      default: pre_term = PMT8_PRE_DIV16;
    endcase

    // Run bit gates prescaler, count and postscaler; instr_cnt still toggles when off
    pre_tick = 1'b0;
    hit      = 1'b0;
    st_next.match_pulse = 1'b0;
    if (st_reg.control[PMT8_RUN_BIT] && instr_tick) begin         // R9
      if (st_reg.pre_cnt >= pre_term) begin                       // R2
        st_next.pre_cnt = 4'h0;
        pre_tick = 1'b1;
      end else begin
        st_next.pre_cnt = st_reg.pre_cnt + 4'h1;
      end
    end
    if (pre_tick) begin                                           // R1
      if (st_reg.count == st_reg.period) begin                    // R4
        st_next.count = 8'h00;
        hit = 1'b1;
      end else begin
        st_next.count = st_reg.count + 8'h01;
      end
    end
    if (hit) begin
      st_next.match_pulse = 1'b1;                                 // R12
      if (st_reg.post_cnt >= st_reg.control[PMT8_POST_LSB+:4]) begin // R8
        st_next.post_cnt = 4'h0;
        st_next.match_flag = 1'b1;                                // R7
      end else begin
        st_next.post_cnt = st_reg.post_cnt + 4'h1;
      end
    end

    // Bus side: one-cycle registered answer, waitrequest high until then
    st_next.bus    = PMT8_BUS_IDLE;
    st_next.waitreq = 1'b1;
    if (wr_acc || rd_acc) begin
      st_next.bus    = PMT8_BUS_ACK;
      st_next.waitreq = 1'b0;
    end
    if (wr_acc) begin
      case (i_avm.address)
        PMT8_ADDR_FLAGS: begin
          // Set wins over a same-cycle clear
          if (!(hit && st_next.post_cnt == 4'h0))
            st_next.match_flag = i_avm.writedata[PMT8_MATCH_FLAG_BIT]; // R14
        end
        PMT8_ADDR_ENABLES: st_next.match_irq_en = i_avm.writedata[PMT8_MATCH_FLAG_BIT];
        PMT8_ADDR_COUNT: begin
          st_next.count    = i_avm.writedata[7:0];                // R6
          st_next.pre_cnt  = 4'h0;                                // R10
          st_next.post_cnt = 4'h0;
        end
        PMT8_ADDR_CONTROL: begin
          st_next.control  = i_avm.writedata[6:0];
          st_next.count    = st_reg.count;                        // R11
          st_next.pre_cnt  = 4'h0;                                // R10
          st_next.post_cnt = 4'h0;
        end
        PMT8_ADDR_PERIOD: st_next.period = i_avm.writedata[7:0];  // R5
        default: ;
      endcase
    end
    if (rd_acc) begin
      case (i_avm.address)
        PMT8_ADDR_FLAGS:   st_next.rdata = {30'h0000_0000, st_reg.match_flag, 1'b0};
        PMT8_ADDR_ENABLES: st_next.rdata = {30'h0000_0000, st_reg.match_irq_en, 1'b0};
        PMT8_ADDR_COUNT:   st_next.rdata = {24'h00_0000, st_reg.count};
        PMT8_ADDR_CONTROL: st_next.rdata = {25'h000_0000, st_reg.control};
        PMT8_ADDR_PERIOD:  st_next.rdata = {24'h00_0000, st_reg.period};
        default:           st_next.rdata = 32'h0000_0000;
      endcase
    end

    st_next.irq = st_next.match_flag && st_next.match_irq_en;     // R14

    if (i_sys_rst) begin
      st_next              = '0;
      st_next.waitreq      = 1'b1;
      st_next.count        = PMT8_COUNT_RST;                      // R6
      st_next.period       = PMT8_PERIOD_RST;                     // R5
      st_next.control      = PMT8_CONTROL_RST;
      st_next.pre_cnt      = 4'h0;                                // R10
      st_next.post_cnt     = 4'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    st_reg <= st_next;
  end

  assign o_avm_readdata    = st_reg.rdata;
  assign o_avm_waitrequest = st_reg.waitreq;
  assign o_ssp_shift_tick  = st_reg.match_pulse;                  // R12
  assign o_pwm_tbase       = '{count: st_reg.count, period_match: st_reg.match_pulse}; // R13
  assign o_irq             = st_reg.irq;

  // Assertions
  sequence seq_wrap;
    (st_reg.control[PMT8_RUN_BIT] && pre_tick && st_reg.count == st_reg.period && !wr_acc);
  endsequence

  AST_WRAP_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R4
    seq_wrap |=> (st_reg.count == 8'h00) && o_ssp_shift_tick)
    else $error("count did not wrap to zero on period match");
  AST_STOPPED: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R9
    !st_reg.control[PMT8_RUN_BIT] && !wr_acc |=> $stable(st_reg.count))
    else $error("count moved while stopped");
  AST_RESET_VALUES: assert property (@(posedge i_clk) // R5
    i_sys_rst |=> st_reg.period == PMT8_PERIOD_RST && st_reg.count == 8'h00)
    else $error("reset values wrong");
  AST_CTRL_KEEPS_COUNT: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R11
    wr_acc && i_avm.address == PMT8_ADDR_CONTROL |=> st_reg.count == $past(st_reg.count) && st_reg.pre_cnt == 4'h0)
    else $error("control write disturbed count");
  AST_COUNT_WRITE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R10
    wr_acc && i_avm.address == PMT8_ADDR_COUNT |=> st_reg.post_cnt == 4'h0 && st_reg.pre_cnt == 4'h0)
    else $error("scalers not cleared on count write");
  AST_PRE_DIV1: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R3
    st_reg.control[1:0] == 2'b00 && st_reg.control[PMT8_RUN_BIT] && instr_tick |-> pre_tick)
    else $error("divide by one prescale missed a tick");
  AST_FLAG_STICKY: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R14
    st_reg.match_flag && !(wr_acc && i_avm.address == PMT8_ADDR_FLAGS) |=> st_reg.match_flag)
    else $error("match flag dropped without clear");
  AST_POST_DIV1: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R8
    hit && st_reg.control[6:3] == 4'h0 |=> st_reg.match_flag)
    else $error("1:1 postscale did not set flag");
  AST_IRQ_GATE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R14
    o_irq |-> st_reg.match_irq_en && st_reg.match_flag)
    else $error("irq without enable and flag");
  AST_BUS_ANSWER: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (rd_acc || wr_acc) |=> !o_avm_waitrequest ##1 o_avm_waitrequest)
    else $error("bus answer not one cycle");

  // Instruction tick and prescaler
  sequence seq_instr_gap;
    !instr_tick [*3] ##1 instr_tick;
  endsequence

  AST_INSTR_PERIOD: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R2
    instr_tick |=> seq_instr_gap)
    else $error("instruction tick not every four clocks");
  AST_NO_TICK_BETWEEN: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R2
    !instr_tick |-> !pre_tick)
    else $error("prescaler ticked without instruction tick");
  AST_PRE_DIV4: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R3
    st_reg.control[PMT8_PRE_LSB+:2] == 2'b01 && st_reg.control[PMT8_RUN_BIT] && instr_tick |-> pre_tick == (st_reg.pre_cnt == 4'h3))
    else $error("divide by four prescale wrong");
  AST_PRE_DIV16: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R3
    st_reg.control[PMT8_PRE_LSB+1] && st_reg.control[PMT8_RUN_BIT] && instr_tick |-> pre_tick == (st_reg.pre_cnt == 4'hf))
    else $error("divide by sixteen prescale wrong");
  AST_NO_TICK_STOPPED: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R9
    !st_reg.control[PMT8_RUN_BIT] |-> !pre_tick)
    else $error("prescaler ticked while stopped");
  AST_PRE_HOLD_STOPPED: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R9
    !st_reg.control[PMT8_RUN_BIT] && !wr_acc |=> $stable(st_reg.pre_cnt))
    else $error("prescaler moved while stopped");

  // Counter and period
  AST_INCREMENT: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R4
    pre_tick && st_reg.count != st_reg.period && !wr_acc |=> st_reg.count == $past(st_reg.count) + 8'h01)
    else $error("count did not advance by one");
  AST_COUNT_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R1
    !pre_tick && !wr_acc |=> $stable(st_reg.count))
    else $error("count moved without prescaled tick");
  AST_COUNT_LOAD: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R6
    wr_acc && i_avm.address == PMT8_ADDR_COUNT |=> st_reg.count == $past(i_avm.writedata[7:0]))
    else $error("count write not loaded");
  AST_PERIOD_WRITE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R5
    wr_acc && i_avm.address == PMT8_ADDR_PERIOD |=> st_reg.period == $past(i_avm.writedata[7:0]))
    else $error("period write not loaded");
  AST_PERIOD_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R5
    !(wr_acc && i_avm.address == PMT8_ADDR_PERIOD) |=> $stable(st_reg.period))
    else $error("period changed without write");
  AST_CTRL_WRITE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R10
    wr_acc && i_avm.address == PMT8_ADDR_CONTROL
      |=> st_reg.control == $past(i_avm.writedata[6:0]) && st_reg.post_cnt == 4'h0)
    else $error("control write not applied");

  // Match pulse, postscaler and flag
  AST_PULSE_CAUSE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R12
    o_ssp_shift_tick |-> $past(hit))
    else $error("shift tick without period match");
  AST_PULSE_FROM_HIT: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R13
    hit |=> o_ssp_shift_tick && o_pwm_tbase.period_match)
    else $error("period match not offered");
  AST_PULSE_SINGLE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R12
    o_ssp_shift_tick |=> !o_ssp_shift_tick)
    else $error("shift tick longer than one cycle");
  AST_POST_ADVANCE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R8
    hit && st_reg.post_cnt < st_reg.control[PMT8_POST_LSB+:4] && !wr_acc
      |=> st_reg.post_cnt == $past(st_reg.post_cnt) + 4'h1)
    else $error("postscaler did not advance");
  AST_POST_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R8
    !hit && !wr_acc |=> $stable(st_reg.post_cnt))
    else $error("postscaler moved without match");
  AST_FLAG_SET: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R7
    hit && st_reg.post_cnt >= st_reg.control[PMT8_POST_LSB+:4] |=> st_reg.match_flag)
    else $error("flag not set at postscale end");
  AST_FLAG_NOT_EARLY: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R7
    !st_reg.match_flag && !wr_acc && !(hit && st_reg.post_cnt >= st_reg.control[PMT8_POST_LSB+:4]) |=> !st_reg.match_flag)
    else $error("flag set early");
  AST_FLAG_CLEAR: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R14
    wr_acc && i_avm.address == PMT8_ADDR_FLAGS && !i_avm.writedata[PMT8_MATCH_FLAG_BIT]
      && !(hit && st_reg.post_cnt >= st_reg.control[PMT8_POST_LSB+:4]) |=> !st_reg.match_flag)
    else $error("flag not cleared by software");
  AST_IRQ_RAISE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R14
    st_reg.match_flag && st_reg.match_irq_en |-> o_irq)
    else $error("irq missing with flag and enable");
  AST_IRQ_ENABLE_WRITE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R14
    wr_acc && i_avm.address == PMT8_ADDR_ENABLES |=> st_reg.match_irq_en == $past(i_avm.writedata[PMT8_MATCH_FLAG_BIT]))
    else $error("enable write not applied");

  // Register bus read-back
  AST_READ_COUNT: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R6
    rd_acc && i_avm.address == PMT8_ADDR_COUNT |=> o_avm_readdata == {24'h00_0000, $past(st_reg.count)})
    else $error("count read-back wrong");
  AST_READ_PERIOD: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R5
    rd_acc && i_avm.address == PMT8_ADDR_PERIOD |=> o_avm_readdata == {24'h00_0000, $past(st_reg.period)})
    else $error("period read-back wrong");
  AST_READ_CONTROL: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R2
    rd_acc && i_avm.address == PMT8_ADDR_CONTROL |=> o_avm_readdata == {25'h000_0000, $past(st_reg.control)})
    else $error("control read-back wrong");
  AST_READ_FLAGS: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R7
    rd_acc && i_avm.address == PMT8_ADDR_FLAGS |=> o_avm_readdata == {30'h0000_0000, $past(st_reg.match_flag), 1'b0})
    else $error("flag read-back wrong");
  AST_READ_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !rd_acc |=> $stable(o_avm_readdata))
    else $error("read data changed without read");
  AST_NO_SPURIOUS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !(rd_acc || wr_acc) |=> o_avm_waitrequest)
    else $error("answer without request");

  // Reset state
  AST_RESET_SCALERS: assert property (@(posedge i_clk) // R10
    i_sys_rst |=> st_reg.pre_cnt == 4'h0 && st_reg.post_cnt == 4'h0 && !st_reg.match_flag)
    else $error("scalers not cleared by reset");
  AST_RESET_OUTPUTS: assert property (@(posedge i_clk) // R6
    i_sys_rst |=> o_avm_waitrequest && !o_irq && !o_ssp_shift_tick && st_reg.control == PMT8_CONTROL_RST)
    else $error("outputs not idle after reset");
endmodule // pmt8_timer
